// >>> verilog/brws_pkg.sv
// brws_pkg: constants shared by the burst read wait sequencer files.
// assumes a single 50 MHz clock domain and no register bus.
package brws_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          LAT_W        = 3;
  // burst length field encodings
  localparam logic [2:0]  BLEN_4       = 3'h1;
  localparam logic [2:0]  BLEN_8       = 3'h2;
  localparam logic [2:0]  BLEN_16      = 3'h3;
  localparam logic [2:0]  BLEN_CONT    = 3'h7;
  // configuration reset values (defaults)
  localparam logic        RST_ASYNC    = 1'h1;
  localparam logic        RST_POL_HIGH = 1'h1;
  localparam logic        RST_HOLD_TWO = 1'h1;
  localparam logic        RST_WDLY_EARLY = 1'h1;
  localparam logic        RST_NOWRAP   = 1'h1;
  localparam logic [2:0]  RST_BLEN     = 3'h7;
  localparam logic [2:0]  RST_LAT      = 3'h3;
  // row and group geometry, in word-address bits
  localparam int          GRP_BITS     = 2;
  localparam int          ROW_BITS     = 4;
  localparam logic [1:0]  GRP_LAST     = 2'h3;
  localparam logic [3:0]  ROW_LAST     = 4'hf;
  // clocks taken off latency for the row crossing delay of a last-of-group start
  localparam logic [2:0]  ROW_LAT_ADJ  = 3'h1;
endpackage

// >>> verilog/brws_addr_step.sv
// brws_addr_step: next burst address for wrap or linear ordering.
// assumes wrap is only applied for 4, 8 or 16 word lengths.
`timescale 1ns/10ps
module brws_addr_step #(
  parameter int ADDR_W = 16
) (
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [2:0]        blen_i,
  input  wire logic              nowrap_i,
  output logic      [ADDR_W-1:0] next_o
);
  logic [ADDR_W-1:0] inc;
  logic [ADDR_W-1:0] wrap_mask;
  logic              do_wrap;

  // mask of address bits that cycle inside the aligned group
  assign inc       = addr_i + {{(ADDR_W-1){1'b0}}, 1'b1};
  assign wrap_mask = (blen_i == brws_pkg::BLEN_4)  ? ADDR_W'(4'h3) :
                     (blen_i == brws_pkg::BLEN_8)  ? ADDR_W'(4'h7) :
                     (blen_i == brws_pkg::BLEN_16) ? ADDR_W'(4'hf) : '0;
  // continuous bursts never wrap, whatever the wrap bit says
  assign do_wrap   = !nowrap_i && (wrap_mask != '0);
  assign next_o    = do_wrap ? ((addr_i & ~wrap_mask) | (inc & wrap_mask))
                             : inc;
endmodule

// >>> verilog/brws_len_count.sv
// brws_len_count: counts words left in a fixed-length burst.
// assumes start_i and word_i never pulse together.
`timescale 1ns/10ps
module brws_len_count (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [2:0] blen_i,
  input  wire logic       word_i,
  output logic            done_o
);
  logic [4:0] left_reg;
  logic [4:0] load_val;
  logic       cont_reg;

  // burst length decode, continuous never ends by count
  assign load_val = (blen_i == brws_pkg::BLEN_4)  ? 5'h04 :
                    (blen_i == brws_pkg::BLEN_8)  ? 5'h08 :
                    (blen_i == brws_pkg::BLEN_16) ? 5'h10 : 5'h00;
  // flags the final word, so the burst stops after exactly length words
  assign done_o   = !cont_reg && (left_reg == 5'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_reg <= 5'h00;
      cont_reg <= 1'b0;
    end else if (start_i) begin
      left_reg <= load_val;
      cont_reg <= (load_val == 5'h00);
    end else if (word_i && left_reg != 5'h00) begin
      left_reg <= left_reg - 5'h01;
    end
  end
endmodule

// >>> verilog/brws_top.sv
// Functional notes
// - synchronous array reads: wait deasserted only while valid data is on bus
// - synchronous status, id or query reads hold wait asserted
// - asynchronous read mode holds wait asserted
// - every write cycle drives wait asserted
// - wait floats with chip select off, driven when on; output enable ignored
// - each output word held one or two clocks per hold select
// - wait delay bit picks assert during delay or one cycle early
// - 4-word aligned linear bursts add no delay at first row crossing
// - misaligned linear bursts delay once, only on 16-word crossing
// - last-of-group start: crossing delay is latency minus one clocks
// - wait asserted during the row crossing delay
// - no-wrap and continuous bursts increment linearly across groups
// - polarity bit 0 asserts wait low, 1 asserts high
// - hold select 0 holds one clock, 1 holds two
// - wait delay bit 0 asserts during delay, 1 one cycle earlier
//
// brws_top: burst read output sequencer driving wait and the word address.
// assumes the array answers any address within one cycle; config arrives
// as plain level ports, latched on cfg_load_i.
`timescale 1ns/10ps
module brws_top #(
  parameter int ADDR_W = brws_pkg::ADDR_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              chip_sel_i,
  input  wire logic              out_en_i,
  input  wire logic              write_i,
  input  wire logic              burst_start_i,
  input  wire logic [ADDR_W-1:0] start_addr_i,
  input  wire logic              part_array_i,
  input  wire logic              cfg_load_i,
  input  wire logic              cfg_async_i,
  input  wire logic [2:0]        cfg_lat_i,
  input  wire logic              cfg_wait_polarity_bit_i,
  input  wire logic              cfg_data_hold_select_i,
  input  wire logic              cfg_wait_delay_bit_i,
  input  wire logic              cfg_nowrap_i,
  input  wire logic [2:0]        cfg_blen_i,
  output logic                   wait_o,
  output logic                   wait_oe_o,
  output logic [ADDR_W-1:0]      word_addr_o,
  output logic                   data_valid_o,
  output logic                   end_of_row_condition_o
);
  typedef enum logic [2:0] {BRWS_IDLE, BRWS_LAT, BRWS_DATA, BRWS_ROWDLY, BRWS_DONE} brws_state_t;

  brws_state_t       state_reg, state_next;
  // read configuration register copy
  logic              async_reg;
  logic [2:0]        lat_reg;
  logic              pol_reg;
  logic              hold_two_reg;
  logic              wdly_early_reg;
  logic              nowrap_reg;
  logic [2:0]        blen_reg;
  // burst state
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_step;
  logic [2:0]        cnt_reg, cnt_next;
  logic              phase_reg, phase_next;
  logic              misalign_reg;
  logic              crossed_reg;
  logic              array_reg;
  logic              len_done;
  logic              word_adv;
  logic              row_cross;
  logic              delay_ahead;
  logic              busy_lvl;
  logic              wait_assert;
  logic              valid_now;
  logic              last_half;
  logic [2:0]        row_dly;
  logic              burst_take;
  logic              at_row_end;

  brws_addr_step #(
    .ADDR_W(ADDR_W)
  ) u_step (
    .addr_i   (addr_reg),
    .blen_i   (blen_reg),
    .nowrap_i (nowrap_reg),
    .next_o   (addr_step)
  );

  brws_len_count u_len (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (burst_take),
    .blen_i  (blen_reg),
    .word_i  (word_adv),
    .done_o  (len_done)
  );

  // a word finishes on its last hold clock
  assign last_half   = !hold_two_reg || phase_reg;
  assign word_adv    = (state_reg == BRWS_DATA) && last_half;
  // crossing only matters for linear bursts; wrap never leaves the group
  // a start only counts when the sequencer really accepts it
  assign burst_take  = (state_reg == BRWS_IDLE) && (state_next == BRWS_LAT);
  assign at_row_end  = (addr_reg[brws_pkg::ROW_BITS-1:0] == brws_pkg::ROW_LAST);
  assign row_cross   = at_row_end
                       && (nowrap_reg || blen_reg == brws_pkg::BLEN_CONT)
                       && misalign_reg && !crossed_reg;
  // worst case for a last-of-group start is latency less one
  assign row_dly     = lat_reg - brws_pkg::ROW_LAT_ADJ;
  // early wait: flag the final data clock before the delay; the word itself
  // stays valid, so a one-clock hold loses no data
  assign delay_ahead = wdly_early_reg && row_cross && (state_reg == BRWS_DATA)
                       && last_half && !len_done;
  assign valid_now   = (state_reg == BRWS_DATA);
  // sync array read is the only case where wait carries meaning
  assign busy_lvl    = async_reg || write_i || !array_reg || !valid_now;
  assign wait_assert = busy_lvl || delay_ahead;

  // state sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    case (state_reg)
      BRWS_IDLE: begin
        phase_next = 1'b0;
        if (burst_start_i && chip_sel_i && !write_i && !async_reg) begin
          state_next = BRWS_LAT;
          cnt_next   = lat_reg;
        end
      end
      BRWS_LAT: begin
        if (cnt_reg <= 3'h1) begin
          state_next = BRWS_DATA;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      BRWS_DATA: begin
        phase_next = hold_two_reg ? !phase_reg : 1'b0;
        if (last_half) begin
          if (len_done) begin
            state_next = BRWS_DONE;
          end else if (row_cross && row_dly != 3'h0) begin
            state_next = BRWS_ROWDLY;
            cnt_next   = row_dly;
          end
        end
      end
      BRWS_ROWDLY: begin
        phase_next = 1'b0;
        if (cnt_reg <= 3'h1) begin
          state_next = BRWS_DATA;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      BRWS_DONE: state_next = BRWS_DONE;
      default:   state_next = BRWS_IDLE;
    endcase
    if (!chip_sel_i || write_i) begin
      state_next = BRWS_IDLE;
    end
  end

  // configuration copy, defaults after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_reg      <= brws_pkg::RST_ASYNC;
      lat_reg        <= brws_pkg::RST_LAT;
      pol_reg        <= brws_pkg::RST_POL_HIGH;
      hold_two_reg   <= brws_pkg::RST_HOLD_TWO;
      wdly_early_reg <= brws_pkg::RST_WDLY_EARLY;
      nowrap_reg     <= brws_pkg::RST_NOWRAP;
      blen_reg       <= brws_pkg::RST_BLEN;
    end else if (cfg_load_i) begin
      async_reg      <= cfg_async_i;
      lat_reg        <= cfg_lat_i;
      pol_reg        <= cfg_wait_polarity_bit_i;
      hold_two_reg   <= cfg_data_hold_select_i;
      wdly_early_reg <= cfg_wait_delay_bit_i;
      nowrap_reg     <= cfg_nowrap_i;
      blen_reg       <= cfg_blen_i;
    end
  end

  // burst address and crossing bookkeeping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= BRWS_IDLE;
      cnt_reg      <= 3'h0;
      phase_reg    <= 1'b0;
      addr_reg     <= '0;
      misalign_reg <= 1'b0;
      crossed_reg  <= 1'b0;
      array_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
      if (burst_take) begin
        addr_reg     <= start_addr_i;
        misalign_reg <= (start_addr_i[brws_pkg::GRP_BITS-1:0] != 2'h0);
        crossed_reg  <= 1'b0;
        array_reg    <= part_array_i;
      end else if (word_adv && !len_done) begin
        addr_reg <= addr_step;
        if (at_row_end) begin
          crossed_reg <= 1'b1;
        end
      end
    end
  end

  // registered pin outputs; out_en_i deliberately plays no part
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_o                 <= brws_pkg::RST_POL_HIGH;
      wait_oe_o              <= 1'b0;
      word_addr_o            <= '0;
      data_valid_o           <= 1'b0;
      end_of_row_condition_o <= 1'b0;
    end else begin
      wait_oe_o              <= chip_sel_i;
      wait_o                 <= wait_assert ? pol_reg : !pol_reg;
      word_addr_o            <= addr_reg;
      data_valid_o           <= valid_now && array_reg && !async_reg && !write_i;
      end_of_row_condition_o <= (state_reg == BRWS_ROWDLY) || delay_ahead;
    end
  end
endmodule

// >>> bench/brws_asserts.sv
// brws_asserts: port-level checks for brws_top.
// assumes cfg inputs change only after chip select has been low a while.
`timescale 1ns/10ps
module brws_asserts #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              chip_sel_i,
  input wire logic              out_en_i,
  input wire logic              write_i,
  input wire logic              burst_start_i,
  input wire logic [ADDR_W-1:0] start_addr_i,
  input wire logic              part_array_i,
  input wire logic              cfg_load_i,
  input wire logic              cfg_async_i,
  input wire logic [2:0]        cfg_lat_i,
  input wire logic              cfg_wait_polarity_bit_i,
  input wire logic              cfg_data_hold_select_i,
  input wire logic              cfg_wait_delay_bit_i,
  input wire logic              cfg_nowrap_i,
  input wire logic [2:0]        cfg_blen_i,
  input wire logic              wait_o,
  input wire logic              wait_oe_o,
  input wire logic [ADDR_W-1:0] word_addr_o,
  input wire logic              data_valid_o,
  input wire logic              end_of_row_condition_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // polarity port equals the latched value while the bus is selected
  wire pol = cfg_wait_polarity_bit_i;
  wire eor = end_of_row_condition_o;
  sequence s_start;
    burst_start_i && chip_sel_i && !write_i && !cfg_async_i;
  endsequence
  sequence s_first;
    (!data_valid_o)[*4] ##1 data_valid_o;
  endsequence
  chk_oe_tracks_cs: assert property (
    !$past(rst_i) |-> wait_oe_o == $past(chip_sel_i)) else $error("wait enable wrong");
  chk_valid_wait_off: assert property (
    data_valid_o && !eor |-> wait_o == !pol) else $error("wait on valid data");
  chk_idle_wait_on: assert property (
    wait_oe_o && !data_valid_o |-> wait_o == pol) else $error("wait off without data");
  chk_write_wait_on: assert property (
    write_i && chip_sel_i |=> wait_o == pol && !data_valid_o) else $error("write wait");
  chk_status_wait_on: assert property (
    s_start ##0 !part_array_i |=> (wait_o == pol && !data_valid_o)[*8])
    else $error("status read wait");
  chk_first_word_lat: assert property (
    s_start ##0 part_array_i && cfg_lat_i == 3'h3 |=> s_first) else $error("first word late");
  chk_hold_two_clk: assert property (
    data_valid_o && $changed(word_addr_o) && cfg_data_hold_select_i |=> $stable(word_addr_o))
    else $error("word held one clock");
  chk_row_delay_len: assert property (
    $rose(eor) && !cfg_wait_delay_bit_i && cfg_lat_i == 3'h3 |->
    (eor && wait_o == pol && !data_valid_o)[*2] ##1 !eor) else $error("row delay length");
  chk_early_wait_on: assert property (
    eor |-> wait_o == pol) else $error("wait off in row delay");
endmodule

// >>> bench/brws_host_model.sv
// brws_host_model: burst master that opens bursts and collects words.
// assumes wait is masked; only the valid flag qualifies a word.
`timescale 1ns/10ps
module brws_host_model (
  input  wire logic        clk_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] addr_i,
  output logic             cs_o,
  output logic             start_o,
  output logic [15:0]      saddr_o
);
  logic [15:0] q[$];
  int          nv = 0;
  logic        pv = 1'h0;
  initial begin
    cs_o = 1'h0;
    start_o = 1'h0;
    saddr_o = 16'hffff;
  end
  // wait is ignored; distinct words are kept, valid cycles counted on the
  // falling edge, where the registered outputs have long settled
  always @(negedge clk_i) begin
    if (valid_i)
      nv++;
    if (valid_i && !(pv && addr_i == q[$]))
      q.push_back(addr_i);
    pv = valid_i;
  end
  task begin_burst(input logic [15:0] a);
    @(posedge clk_i);
    #1;
    q.delete();
    nv = 0;
    cs_o = 1'h1;
    start_o = 1'h1;
    saddr_o = a;
    @(posedge clk_i);
    #1;
    start_o = 1'h0;
    saddr_o = ~a; // stale address never left on the bus
  endtask
  // deselect long enough for the enable to drop before new config
  task end_burst;
    @(posedge clk_i);
    #1;
    cs_o = 1'h0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
endmodule

// >>> bench/brws_tb_top.sv
// brws_tb_top: directed bench for brws_top with a host model.
// assumes latency code 3 throughout; cfg changes only with chip select low.
`timescale 1ns/10ps
module brws_tb_top;
  logic        clk = 1'h0, rst = 1'h1, oen = 1'h0, wr = 1'h0, pa = 1'h1, ld = 1'h0;
  logic        as = 1'h1, pol = 1'h1, hold = 1'h1, wd = 1'h1, nw = 1'h1;
  logic [2:0]  lat = 3'h3, bl = 3'h7;
  logic        cs, st, w, woe, dv, eor;
  logic [15:0] sa, wa;
  int          fail_count = 0, tests_run = 0, ne = 0;
  always #10 clk = ~clk;
  // output enable toggles freely; wait must not care
  always @(posedge clk) #1 oen = ~oen;
  always @(negedge clk) if (eor === 1'h1) ne++;
  brws_top brws_top_inst (.clk_i(clk), .rst_i(rst), .chip_sel_i(cs), .out_en_i(oen),
    .write_i(wr), .burst_start_i(st), .start_addr_i(sa), .part_array_i(pa), .cfg_load_i(ld),
    .cfg_async_i(as), .cfg_lat_i(lat), .cfg_wait_polarity_bit_i(pol),
    .cfg_data_hold_select_i(hold), .cfg_wait_delay_bit_i(wd), .cfg_nowrap_i(nw),
    .cfg_blen_i(bl), .wait_o(w), .wait_oe_o(woe), .word_addr_o(wa), .data_valid_o(dv),
    .end_of_row_condition_o(eor));
  brws_host_model brws_host_model_inst (.clk_i(clk), .valid_i(dv), .addr_i(wa), .cs_o(cs),
    .start_o(st), .saddr_o(sa));
  task chk(input logic [15:0] s, e, input string n);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task cfg(input logic a, p, h, d, n, input logic [2:0] b);
    {as, pol, hold, wd, nw, bl, ld} = {a, p, h, d, n, b, 1'h1};
    @(posedge clk);
    #1;
    ld = 1'h0;
  endtask
  // one burst, first n distinct words compared; m masks the wrap group
  task burst(input logic [15:0] a, input int m, n);
    int k;
    k = 0;
    brws_host_model_inst.begin_burst(a);
    while (brws_host_model_inst.q.size() < n && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k == 200) begin
      fail_count++;
      test_done();
    end
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < n; i++)
      chk(brws_host_model_inst.q[i], 16'((a & ~m) | ((a + i) & m)), "word");
    brws_host_model_inst.end_burst;
  endtask
  task t_wrap; // wrap order at each fixed length, one-clock words
    for (int j = 1; j < 4; j++) begin
      cfg(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 3'(j));
      burst(16'(16'h0025 + j), (2 << j) - 1, 2 << j);
    end
  endtask
  task t_linear; // last-of-group start crosses the row, low wait, two clocks
    cfg(1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 3'h2);
    ne = 0;
    burst(16'h000b, 'hffff, 8);
    chk(16'(ne), 16'h2, "row delay");
    chk(16'(brws_host_model_inst.nv), 16'h10, "held cycles");
  endtask
  task t_aligned; // early wait on a one-clock misaligned burst, then an aligned one
    cfg(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 3'h2);
    ne = 0;
    burst(16'h000b, 'hffff, 8);
    chk(16'(ne), 16'h3, "early row delay");
    chk(16'(brws_host_model_inst.nv), 16'h8, "one-clock words");
    cfg(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 3'h7);
    ne = 0;
    burst(16'h000c, 'hffff, 10);
    chk(16'(ne), 16'h0, "aligned delay");
  endtask
  task t_quiet; // status read, async mode and a write keep wait asserted
    pa = 1'h0;
    brws_host_model_inst.begin_burst(16'h0004);
    repeat (9) @(posedge clk);
    #1;
    chk(16'(brws_host_model_inst.nv), 16'h0, "status data");
    brws_host_model_inst.end_burst;
    pa = 1'h1;
    cfg(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 3'h7);
    brws_host_model_inst.begin_burst(16'h0004);
    repeat (9) @(posedge clk);
    #1;
    chk(16'(w), 16'h1, "async wait");
    chk(16'(brws_host_model_inst.nv), 16'h0, "async data");
    brws_host_model_inst.end_burst;
    cfg(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 3'h7);
    brws_host_model_inst.begin_burst(16'h0004);
    repeat (4) @(posedge clk);
    #1;
    wr = 1'h1;
    @(posedge clk);
    #1;
    chk(16'({w, dv}), 16'h2, "write wait");
    wr = 1'h0;
    brws_host_model_inst.end_burst;
    chk(16'(woe), 16'h0, "released wait");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'h0;
    t_wrap;
    t_linear;
    t_aligned;
    t_quiet;
    test_done;
  end
endmodule
bind brws_top brws_asserts #(.ADDR_W(ADDR_W)) brws_asserts_inst (.*);
